//--- ifeb_consts.vh
/*
 * constants of the interrupt flag and enable bank: register byte offsets,
 * implemented-bit masks, reset values, priority field encodings.
 * assumes inclusion by ifeb_top.v and ifeb_prio.v only.
 */
`ifndef IFEB_CONSTS_VH
`define IFEB_CONSTS_VH

// ----------------------------------------
// register byte offsets (word aligned)
// ----------------------------------------
`define IFEB_OFS_FLAGS_1    12'h000
`define IFEB_OFS_FLAGS_2    12'h004
`define IFEB_OFS_FLAGS_3    12'h008
`define IFEB_OFS_FLAGS_4    12'h00C
`define IFEB_OFS_ENABLES_0  12'h010
`define IFEB_OFS_ENABLES_1  12'h014
`define IFEB_OFS_FLAGS_0    12'h018
`define IFEB_OFS_PRIO_0     12'h020
`define IFEB_OFS_PRIO_1     12'h024
`define IFEB_OFS_IRQ_STAT   12'h030
`define IFEB_OFS_IRQ_MASK   12'h034

// ----------------------------------------
// implemented-bit masks
// ----------------------------------------
`define IFEB_MASK_FLAGS_1   16'h201F
`define IFEB_MASK_FLAGS_2   16'h0020
`define IFEB_MASK_FLAGS_3   16'hC200
`define IFEB_MASK_FLAGS_4   16'h2003
`define IFEB_MASK_ENABLES_0 16'h3FEF
`define IFEB_MASK_ENABLES_1 16'h201F
`define IFEB_MASK_IRQ_STAT  16'h0003

// ----------------------------------------
// bit positions
// ----------------------------------------
`define IFEB_BIT_EXT2       13
`define IFEB_BIT_EXT1       4
`define IFEB_BIT_CHANGE     3
`define IFEB_BIT_COMPARATOR 2
`define IFEB_BIT_I2C_MASTER 1
`define IFEB_BIT_I2C_SLAVE  0
`define IFEB_BIT_CAPTURE3   5
`define IFEB_BIT_FAULT_A    15
`define IFEB_BIT_RTC        14
`define IFEB_BIT_PWM_EVENT  9
`define IFEB_BIT_CHARGE     13
`define IFEB_BIT_UART_ERR   1
`define IFEB_BIT_FAULT_B    0
`define IFEB_STAT_REQ       0
`define IFEB_STAT_ERR       1

// ----------------------------------------
// reset values and priority encodings
// ----------------------------------------
`define IFEB_RST_REG        16'h0000
`define IFEB_RST_PRIO       3'h4
`define IFEB_PRIO_OFF       3'h0
`define IFEB_PRIO_TOP       3'h7

`endif

//--- ifeb_prio.v
/*
 * priority picker over a set of pending sources, each with a 3-bit level.
 * assumes pending is flag and enable already combined; level 0 never wins.
 */
`timescale 1ns/1ns
`include "ifeb_consts.vh"

module ifeb_prio #(
    parameter N = 16
) (
    input  wire [N-1:0]   pend,
    input  wire [3*N-1:0] level,
    output reg  [2:0]     win_level,
    output reg  [7:0]     win_index
);

    integer i;

    // ----------------------------------------
    // pick
    // ----------------------------------------
    // lowest index wins among equal levels, as a fixed natural order
    always @* begin
        win_level = `IFEB_PRIO_OFF;
        win_index = 8'h00;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pend[i] && level[3*i +: 3] != `IFEB_PRIO_OFF &&
                level[3*i +: 3] >= win_level) begin
                win_level = level[3*i +: 3];
                win_index = i[7:0];
            end
        end
    end

endmodule // ifeb_prio

//--- ifeb_top.v
/*
 * interrupt flag and enable bank with an AHB-Lite register slave,
 * a priority picker and a masked level interrupt for request edges and bus errors.
 * assumes src_evt and src0_evt are one-clock pulses from on-chip logic
 * on clk; the cpu reads cpu_req/cpu_level/cpu_index.
 */
// Functional notes
// - flags 1 hold ext2 bit13, ext1 4, change 3, comparator 2, i2c 1/0.
// - flags 2 hold only capture3 at bit 5.
// - flags 3 hold fault A 15, rtc 14, pwm event 9.
// - flags 4 hold charge measure 13, uart error 1, fault B 0.
// - enables 0 hold adc..ext0 at bits 13..0, bit 4 absent.
// - enables 1 mirror flags 1 layout.
// - a flag reads one once its source requested.
// - an enable of one lets its source request through.
// - unimplemented bits read zero and ignore writes.
// - all flags and enables are zero after reset.
// - software reads and writes every flag and enable bit.
// - priority 000 disables a source, 111 is highest.
`timescale 1ns/1ns
`include "ifeb_consts.vh"

module ifeb_top (
    input  wire        clk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire [63:0] src_evt,
    input  wire [15:0] src0_evt,
    output wire        cpu_req,
    output wire [2:0]  cpu_level,
    output wire [7:0]  cpu_index,
    output wire        irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg  [15:0] flags0_q;
    reg  [15:0] flags1_q;
    reg  [15:0] flags2_q;
    reg  [15:0] flags3_q;
    reg  [15:0] flags4_q;
    reg  [15:0] en0_q;
    reg  [15:0] en1_q;
    reg  [15:0] prio0_q;
    reg  [15:0] prio1_q;
    reg  [15:0] stat_q;
    reg  [15:0] mask_q;
    reg  [31:0] rdata_q;
    reg         wr_q;
    reg  [11:0] addr_q;
    reg  [2:0]  lvl_q;
    reg  [7:0]  idx_q;
    reg         req_q;
    reg         req_prev_q;
    wire        take;
    wire        rd_take;
    wire [15:0] wd;
    reg         wr_unmapped;
    reg  [31:0] rdata_d;
    wire [15:0] pend;
    wire [47:0] lvls;
    wire [2:0]  win_level;
    wire [7:0]  win_index;

    assign take      = hsel && hready && htrans[1];
    assign rd_take   = take && !hwrite;
    assign wd        = hwdata[15:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // ----------------------------------------
    // address phase capture
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q   <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_q   <= take && hwrite;
            addr_q <= haddr[11:0];
        end
    end

    always @* begin
        wr_unmapped = wr_q;
        if (addr_q == `IFEB_OFS_FLAGS_0 || addr_q == `IFEB_OFS_FLAGS_1 ||
            addr_q == `IFEB_OFS_FLAGS_2 || addr_q == `IFEB_OFS_FLAGS_3 ||
            addr_q == `IFEB_OFS_FLAGS_4 || addr_q == `IFEB_OFS_ENABLES_0 ||
            addr_q == `IFEB_OFS_ENABLES_1 || addr_q == `IFEB_OFS_PRIO_0 ||
            addr_q == `IFEB_OFS_PRIO_1 || addr_q == `IFEB_OFS_IRQ_STAT ||
            addr_q == `IFEB_OFS_IRQ_MASK) begin
            wr_unmapped = 1'b0;
        end
    end

    // ----------------------------------------
    // flags: event set beats software clear
    // ----------------------------------------
    // write data lands one cycle after the address, so a pulse in the
    // write cycle still sticks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flags0_q <= `IFEB_RST_REG;
            flags1_q <= `IFEB_RST_REG;
            flags2_q <= `IFEB_RST_REG;
            flags3_q <= `IFEB_RST_REG;
            flags4_q <= `IFEB_RST_REG;
        end else begin
            if (wr_q && addr_q == `IFEB_OFS_FLAGS_0) begin
                flags0_q <= (wd | src0_evt) & `IFEB_MASK_ENABLES_0;
            end else begin
                flags0_q <= (flags0_q | src0_evt) & `IFEB_MASK_ENABLES_0;
            end
            if (wr_q && addr_q == `IFEB_OFS_FLAGS_1) begin
                flags1_q <= (wd | src_evt[15:0]) & `IFEB_MASK_FLAGS_1;
            end else begin
                flags1_q <= (flags1_q | src_evt[15:0]) & `IFEB_MASK_FLAGS_1;
            end
            if (wr_q && addr_q == `IFEB_OFS_FLAGS_2) begin
                flags2_q <= (wd | src_evt[31:16]) & `IFEB_MASK_FLAGS_2;
            end else begin
                flags2_q <= (flags2_q | src_evt[31:16]) & `IFEB_MASK_FLAGS_2;
            end
            if (wr_q && addr_q == `IFEB_OFS_FLAGS_3) begin
                flags3_q <= (wd | src_evt[47:32]) & `IFEB_MASK_FLAGS_3;
            end else begin
                flags3_q <= (flags3_q | src_evt[47:32]) & `IFEB_MASK_FLAGS_3;
            end
            if (wr_q && addr_q == `IFEB_OFS_FLAGS_4) begin
                flags4_q <= (wd | src_evt[63:48]) & `IFEB_MASK_FLAGS_4;
            end else begin
                flags4_q <= (flags4_q | src_evt[63:48]) & `IFEB_MASK_FLAGS_4;
            end
        end
    end

    // ----------------------------------------
    // enables, priorities, irq status/mask
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            en0_q   <= `IFEB_RST_REG;
            en1_q   <= `IFEB_RST_REG;
            prio0_q <= {1'b0, `IFEB_RST_PRIO, 1'b0, `IFEB_RST_PRIO,
                        1'b0, `IFEB_RST_PRIO, 1'b0, `IFEB_RST_PRIO};
            prio1_q <= {1'b0, `IFEB_RST_PRIO, 1'b0, `IFEB_RST_PRIO,
                        1'b0, `IFEB_RST_PRIO, 1'b0, `IFEB_RST_PRIO};
            stat_q  <= `IFEB_RST_REG;
            mask_q  <= `IFEB_RST_REG;
        end else begin
            if (wr_q && addr_q == `IFEB_OFS_ENABLES_0) begin
                en0_q <= wd & `IFEB_MASK_ENABLES_0;
            end
            if (wr_q && addr_q == `IFEB_OFS_ENABLES_1) begin
                en1_q <= wd & `IFEB_MASK_ENABLES_1;
            end
            if (wr_q && addr_q == `IFEB_OFS_PRIO_0) begin
                prio0_q <= wd & 16'h7777;
            end
            if (wr_q && addr_q == `IFEB_OFS_PRIO_1) begin
                prio1_q <= wd & 16'h7777;
            end
            if (wr_q && addr_q == `IFEB_OFS_IRQ_MASK) begin
                mask_q <= wd & `IFEB_MASK_IRQ_STAT;
            end
            // set wins over write-one-to-clear
            stat_q[`IFEB_STAT_REQ] <= (req_q && !req_prev_q) ||
                (stat_q[`IFEB_STAT_REQ] &&
                 !(wr_q && addr_q == `IFEB_OFS_IRQ_STAT && wd[`IFEB_STAT_REQ]));
            stat_q[`IFEB_STAT_ERR] <= wr_unmapped ||
                (stat_q[`IFEB_STAT_ERR] &&
                 !(wr_q && addr_q == `IFEB_OFS_IRQ_STAT && wd[`IFEB_STAT_ERR]));
            stat_q[15:2] <= 14'h0000;
        end
    end

    // rising request edge, taken from the registered request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            req_prev_q <= 1'b0;
        end else begin
            req_prev_q <= req_q;
        end
    end

    // ----------------------------------------
    // request to cpu
    // ----------------------------------------
    // only enables 0 and 1 exist here; sources in flags 2..4 have their
    // enables elsewhere and are not routed to the picker
    assign pend = flags0_q & en0_q;
    assign lvls = {8{prio1_q[2:0], prio0_q[2:0]}};

    ifeb_prio #(
        .N (16)
    ) u_prio (
        .pend      (pend),
        .level     (lvls),
        .win_level (win_level),
        .win_index (win_index)
    );

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= 1'b0;
            lvl_q <= 3'h0;
            idx_q <= 8'h00;
        end else begin
            req_q <= (win_level != `IFEB_PRIO_OFF) || |(flags1_q & en1_q);
            lvl_q <= win_level;
            idx_q <= win_index;
        end
    end

    assign cpu_req   = req_q;
    assign cpu_level = lvl_q;
    assign cpu_index = idx_q;
    assign irq       = |(stat_q & mask_q);

    // ----------------------------------------
    // read path, registered in the data phase
    // ----------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        if (haddr[11:0] == `IFEB_OFS_FLAGS_1) begin
            rdata_d = {16'h0000, flags1_q};
        end else if (haddr[11:0] == `IFEB_OFS_FLAGS_2) begin
            rdata_d = {16'h0000, flags2_q};
        end else if (haddr[11:0] == `IFEB_OFS_FLAGS_3) begin
            rdata_d = {16'h0000, flags3_q};
        end else if (haddr[11:0] == `IFEB_OFS_FLAGS_4) begin
            rdata_d = {16'h0000, flags4_q};
        end else if (haddr[11:0] == `IFEB_OFS_ENABLES_0) begin
            rdata_d = {16'h0000, en0_q};
        end else if (haddr[11:0] == `IFEB_OFS_ENABLES_1) begin
            rdata_d = {16'h0000, en1_q};
        end else if (haddr[11:0] == `IFEB_OFS_FLAGS_0) begin
            rdata_d = {16'h0000, flags0_q};
        end else if (haddr[11:0] == `IFEB_OFS_PRIO_0) begin
            rdata_d = {16'h0000, prio0_q};
        end else if (haddr[11:0] == `IFEB_OFS_PRIO_1) begin
            rdata_d = {16'h0000, prio1_q};
        end else if (haddr[11:0] == `IFEB_OFS_IRQ_STAT) begin
            rdata_d = {16'h0000, stat_q};
        end else if (haddr[11:0] == `IFEB_OFS_IRQ_MASK) begin
            rdata_d = {16'h0000, mask_q};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end
    end

endmodule // ifeb_top

//--- ifeb_properties.sv
/* assertions on the flag and enable bank's bus and request ports.
   assumes a bind to ifeb_top and a slave without wait states. */
`timescale 1ns/1ns
module ifeb_props (
    input wire        clk,
    input wire        rst,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire [63:0] src_evt,
    input wire [15:0] src0_evt,
    input wire        cpu_req,
    input wire [2:0]  cpu_level,
    input wire        irq
);
// ----------------------------------------
// transfer tracking
// ----------------------------------------
reg        rd_q;
reg        wr_q;
reg [11:0] ofs_q;
wire       go    = hsel & hready & htrans[1];
wire       ev    = (|src_evt) | (|src0_evt);
wire       quiet = ~ev & ~wr_q;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        rd_q  <= 1'b0;
        wr_q  <= 1'b0;
        ofs_q <= 12'h000;
    end else begin
        rd_q  <= go & ~hwrite;
        wr_q  <= go & hwrite;
        ofs_q <= haddr[11:0];
    end
end
// places other than flags 1..4 and enables 0/1 leave the low half free
function automatic [15:0] imask(input [11:0] o);
    case (o)
        12'h000: imask = 16'h201F;
        12'h004: imask = 16'h0020;
        12'h008: imask = 16'hC200;
        12'h00C: imask = 16'h2003;
        12'h010: imask = 16'h3FEF;
        12'h014: imask = 16'h201F;
        default: imask = 16'hFFFF;
    endcase
endfunction
// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
ready_high_a: assert property (hreadyout)
    else $error("wait state inserted");
okay_resp_a: assert property (!hresp)
    else $error("error response");
unimpl_zero_a: assert property (rd_q |-> (hrdata & ~{16'h0000, imask(ofs_q)}) == 32'h0)
    else $error("unimplemented bit read as one");
evt_sets_flag_a: assert property ((|src_evt[15:0]) ##1 (go && !hwrite && !wr_q
    && haddr[11:0] == 12'h000) |=> (hrdata[15:0] & $past(src_evt[15:0], 2) & 16'h201F)
    == ($past(src_evt[15:0], 2) & 16'h201F)) else $error("event did not set flag");
req_cause_a: assert property ($rose(cpu_req) |-> $past(ev, 2) || $past(wr_q, 2))
    else $error("request rose without cause");
req_stable_a: assert property (quiet [*3] |=> $stable(cpu_req))
    else $error("request moved while idle");
reset_quiet_a: assert property ($fell(rst) |-> !cpu_req && !irq && cpu_level == 3'h0)
    else $error("outputs active after reset");
hold_rdata_a: assert property (!(go && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without read");
cover property (rd_q && ofs_q == 12'h014);
cover property ($rose(cpu_req));
cover property ($rose(irq));
endmodule // ifeb_props

//--- ifeb_sources.sv
/* model of the peripheral request sources beside the bank.
   assumes the bench raises fire for one clock with a pattern. */
`timescale 1ns/1ns
module ifeb_sources (
    input  wire        clk,
    input  wire        rst,
    input  wire        fire,
    input  wire [79:0] pattern,
    output reg  [63:0] src_evt,
    output reg  [15:0] src0_evt
);
// ----------------------------------------
// one-clock pulses, unimplemented bits too
// ----------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        {src0_evt, src_evt} <= 80'h0;
    end else begin
        {src0_evt, src_evt} <= fire ? pattern : 80'h0;
    end
end
endmodule // ifeb_sources

//--- irq_flag_enable_bank_bench.sv
/* self-checking bench of the flag and enable bank.
   assumes ifeb_top, ifeb_sources and ifeb_props are compiled first. */
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
    num_errors = num_errors + 1; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module irq_flag_enable_bank_bench;
reg         clk, rst, hsel, hwrite, fire;
reg  [1:0]  htrans;
reg  [31:0] haddr, hwdata, rd, seed;
reg  [79:0] pattern;
reg  [63:0] evs;
wire [31:0] hrdata;
wire        hreadyout, hresp, cpu_req, irq;
wire [2:0]  cpu_level;
wire [7:0]  cpu_index;
wire [63:0] src_evt;
wire [15:0] src0_evt;
integer     num_errors, n_compared, cycles, i, k;
ifeb_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_evt(src_evt), .src0_evt(src0_evt),
    .cpu_req(cpu_req), .cpu_level(cpu_level), .cpu_index(cpu_index), .irq(irq));
ifeb_sources u_src (.clk(clk), .rst(rst), .fire(fire), .pattern(pattern),
    .src_evt(src_evt), .src0_evt(src0_evt));
// ----------------------------------------
// helpers
// ----------------------------------------
function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
endfunction
function [15:0] fmask(input integer n);
    case (n)
        0: fmask = 16'h201F;
        1: fmask = 16'h0020;
        2: fmask = 16'hC200;
        3: fmask = 16'h2003;
        4: fmask = 16'h3FEF;
        default: fmask = 16'h201F;
    endcase
endfunction
// waits on hreadyout; no latency assumed
task bus(input [11:0] a, input w, input [31:0] d);
    begin
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    end
endtask
task rchk(input [11:0] a, input [15:0] e);
    begin
        bus(a, 1'b0, 32'h0);
        `CHK(rd, {16'h0, e})
    end
endtask
task evt(input [79:0] p);
    begin
        fire <= 1'b1;
        pattern <= p;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
    end
endtask
task tally_and_finish;
    begin
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    end
endtask
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
        num_errors = num_errors + 1;
        tally_and_finish;
    end
end
// ----------------------------------------
// scenarios
// ----------------------------------------
initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, fire, pattern} = {2'h3, 148'h0};
    {num_errors, n_compared, cycles} = 96'h0;
    seed = 32'h00006CCF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 6; i = i + 1) rchk({i[9:0], 2'h0}, 16'h0000);
    `CHK(cpu_req, 1'b0)
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
        bus({i[9:0], 2'h0}, 1'b1, 32'hFFFFFFFF);
        rchk({i[9:0], 2'h0}, fmask(i));
        bus({i[9:0], 2'h0}, 1'b1, 32'h0);
        rchk({i[9:0], 2'h0}, 16'h0000);
    end
    $display("test layout done");
    for (k = 0; k < 20; k = k + 1) begin
        seed = xs(seed);
        evs = (k == 0) ? {64{1'b1}} : {seed, xs(seed)};
        seed = evs[31:0];
        evt({16'h0, evs}); // enables still zero here
        for (i = 0; i < 4; i = i + 1) rchk({i[9:0], 2'h0}, evs[16*i +: 16] & fmask(i));
        `CHK(cpu_req, 1'b0)
        for (i = 0; i < 4; i = i + 1) bus({i[9:0], 2'h0}, 1'b1, 32'h0);
    end
    $display("test events done");
    bus(12'h034, 1'b1, 32'h1);
    evt(80'h2000);
    rchk(12'h000, 16'h2000);
    `CHK(cpu_req, 1'b0)
    bus(12'h014, 1'b1, 32'h2000);
    for (k = 0; k < 8 && irq !== 1'b1; k = k + 1) @(posedge clk);
    `CHK(cpu_req, 1'b1)
    `CHK(irq, 1'b1)
    bus(12'h030, 1'b1, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    bus(12'h040, 1'b1, 32'h1);
    rchk(12'h030, 16'h0002);
    `CHK(irq, 1'b0)
    bus(12'h034, 1'b1, 32'h3);
    @(posedge clk);
    `CHK(irq, 1'b1)
    bus(12'h030, 1'b1, 32'h3);
    bus(12'h000, 1'b1, 32'h0);
    bus(12'h014, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(cpu_req, 1'b0)
    $display("test interrupt done");
    bus(12'h010, 1'b1, 32'h3);
    evt({16'h0003, 64'h0});
    repeat (2) @(posedge clk);
    `CHK({cpu_req, cpu_level, cpu_index}, 12'hC00)
    bus(12'h020, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    `CHK({cpu_req, cpu_level, cpu_index}, 12'hC01)
    bus(12'h024, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(cpu_req, 1'b0)
    bus(12'h020, 1'b1, 32'h7777);
    repeat (2) @(posedge clk);
    `CHK({cpu_req, cpu_level, cpu_index}, 12'hF00)
    $display("test priority done");
    tally_and_finish;
end
endmodule // irq_flag_enable_bank_bench
bind ifeb_top ifeb_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_evt(src_evt), .src0_evt(src0_evt),
    .cpu_req(cpu_req), .cpu_level(cpu_level), .irq(irq));
